// >>> common/ppm_pkg.sv
// constants for the port pin function multiplexer
package ppm_pkg;
  localparam int NPORT = 10;
  // register address: [7:6] group, [5:2] port index
  localparam int GRP_MSB = 7;
  localparam int GRP_LSB = 6;
  localparam int IDX_MSB = 5;
  localparam int IDX_LSB = 2;
  localparam logic [1:0] GRP_DATA = 2'h0;
  localparam logic [1:0] GRP_DIR  = 2'h1;
  localparam logic [1:0] GRP_FSEL = 2'h2;
  localparam logic [1:0] GRP_CTRL = 2'h3;
  localparam logic [3:0] IDX_MODE = 4'h0;
  localparam logic [3:0] IDX_EDGE = 4'h1;
  // which port indices exist in each group
  localparam logic [15:0] DATA_MAP = 16'h03bf;
  localparam logic [15:0] DIR_MAP  = 16'h033b;
  localparam logic [15:0] FSEL_MAP = 16'h0109;
  // implemented pins per port, index 9 first
  localparam logic [9:0][7:0] PORT_MASK = {8'h0f, 8'h3f, 8'hff, 8'h00,
    8'hff, 8'hff, 8'h7f, 8'h3f, 8'hff, 8'hff};
  localparam logic [7:0] LAT_RST  = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'hff;
  localparam logic [7:0] FSEL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] EDGE_RST = 8'h3f;
  // mode register bits
  localparam int MODE_EXTMEM = 0;
  localparam int MODE_P05_IN = 1;
  localparam int MODE_P06_IN = 2;
  // port numbers
  localparam int P0 = 0;
  localparam int P1 = 1;
  localparam int P2 = 2;
  localparam int P3 = 3;
  localparam int P4 = 4;
  localparam int P5 = 5;
  localparam int P7 = 7;
  localparam int P8 = 8;
  localparam int P9 = 9;
  // pin positions
  localparam int RTP_W   = 4;
  localparam int P0_PWMA = 4;
  localparam int P0_PWMB = 5;
  localparam int P0_TMR  = 6;
  localparam int P0_CLR  = 7;
  localparam int P2_NMI  = 0;
  localparam int P2_IRQ  = 1;
  localparam int P2_TI   = 4;
  localparam int P3_TXA  = 0;
  localparam int P3_RXA  = 1;
  localparam int P3_SO   = 2;
  localparam int P3_SI   = 3;
  localparam int P3_SCK  = 4;
  localparam int P3_TXB  = 5;
  localparam int P3_RXB  = 6;
  localparam int P9_RD   = 0;
  localparam int P9_WR   = 1;
  localparam int P8_W    = 6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ppm_pkg

// >>> common/ppm_pin_if.sv
// carrier for raw pin levels and their synchronised copies
`timescale 1ns/1ps
interface ppm_pin_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface : ppm_pin_if

// >>> src/ppm_sync.sv
// two-flop synchroniser for all pin inputs
`timescale 1ns/1ps
module ppm_sync #(
  parameter int W = 8
) (
  input  wire logic clock_i,
  input  wire logic rstn_i,
  ppm_pin_if.dst    pins
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppm_sync_st_t;

  ppm_sync_st_t q;
  ppm_sync_st_t d;

  // first stage feeds only the second stage
  always_comb begin
    d    = q;
    d.s1 = pins.raw;
    d.s2 = q.s1;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins.sync = q.s2;
endmodule : ppm_sync

// >>> src/ppm_top.sv
// port pin function multiplexer with axi4-lite register access
`timescale 1ns/1ps
module ppm_top (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  input  wire logic [7:0]  p0_i,
  output logic [7:0]       p0_o,
  output logic [7:0]       p0_oe_o,
  input  wire logic [7:0]  p1_i,
  output logic [7:0]       p1_o,
  output logic [7:0]       p1_oe_o,
  input  wire logic [5:0]  p2_i,
  input  wire logic [6:0]  p3_i,
  output logic [6:0]       p3_o,
  output logic [6:0]       p3_oe_o,
  input  wire logic [7:0]  p4_i,
  output logic [7:0]       p4_o,
  output logic [7:0]       p4_oe_o,
  input  wire logic [7:0]  p5_i,
  output logic [7:0]       p5_o,
  output logic [7:0]       p5_oe_o,
  input  wire logic [7:0]  p7_i,
  input  wire logic [5:0]  p8_i,
  output logic [5:0]       p8_o,
  output logic [5:0]       p8_oe_o,
  input  wire logic [3:0]  p9_i,
  output logic [3:0]       p9_o,
  output logic [3:0]       p9_oe_o,
  output logic             address_latch_strobe_o,
  output logic             watchdog_overflow_out_o,
  input  wire logic [3:0]  realtime_outputs_i,
  input  wire logic        realtime_trigger_i,
  input  wire logic        pulse_width_out_a_i,
  input  wire logic        pulse_width_out_b_i,
  input  wire logic        updown_timer_output_i,
  output logic             updown_timer_count_clock_o,
  output logic             updown_timer_direction_ctl_o,
  output logic             updown_timer_clear_o,
  output logic             timer_one_count_clock_o,
  output logic             nmi_request_o,
  output logic [4:0]       external_irq_inputs_o,
  input  wire logic        async_tx_a_i,
  output logic             async_rx_a_o,
  input  wire logic        async_tx_b_i,
  output logic             async_rx_b_o,
  input  wire logic        serial_bus_mode_i,
  input  wire logic        csi_out_a_i,
  input  wire logic        csi_out_b_i,
  output logic             serial_bus_line_a_o,
  output logic             serial_bus_line_b_o,
  input  wire logic        csi_clock_out_i,
  input  wire logic        csi_clock_oe_i,
  output logic             csi_clock_in_o,
  output logic [7:0]       analog_channel_inputs_o,
  input  wire logic [5:0]  pulse_unit_outputs_i,
  input  wire logic [7:0]  bus_ad_out_i,
  input  wire logic        bus_ad_oe_i,
  input  wire logic [7:0]  bus_addr_hi_i,
  input  wire logic        bus_rd_n_i,
  input  wire logic        bus_wr_n_i,
  input  wire logic        bus_address_latch_strobe_i,
  output logic [7:0]       bus_ad_in_o,
  output logic [7:0]       muxed_addr_data_bus_o,
  input  wire logic        watchdog_overflow_i
);
  localparam int SYNC_W = 63;

  typedef struct packed {
    logic [9:0][7:0] lat;
    logic [9:0][7:0] dir;
    logic [9:0][7:0] fsel;
    logic [7:0]      mode;
    logic [7:0]      edge_pol;
    logic [3:0]      rtp;
    logic [5:0]      p2_prev;
    logic            aw_ok;
    logic            w_ok;
    logic [7:0]      awaddr;
    logic [7:0]      wdata;
    logic            wstb;
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic [9:0][7:0] pin_o;
    logic [9:0][7:0] pin_oe;
    logic            tmr_clk;
    logic            tmr_dir;
    logic            tmr_clr;
    logic            ti;
    logic            nmi;
    logic [4:0]      irq;
    logic            rxa;
    logic            rxb;
    logic            sba;
    logic            sbb;
    logic            sck;
    logic [7:0]      ani;
    logic [7:0]      ad_in;
    logic            address_latch_strobe;
    logic            wdt;
  } ppm_state_t;

  ppm_state_t      q;
  ppm_state_t      d;
  logic [9:0][7:0] pin;
  ppm_pin_if #(.W(SYNC_W)) pin_bus ();

  assign pin_bus.raw = {p9_i, p8_i, p7_i, p5_i, p4_i, p3_i, p2_i, p1_i,
                        p0_i};

  ppm_sync #(.W(SYNC_W)) u_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .pins    (pin_bus.dst)
  );

  always_comb begin
    pin       = '0;
    pin[0]    = pin_bus.sync[7:0];
    pin[1]    = pin_bus.sync[15:8];
    pin[2]    = {2'h0, pin_bus.sync[21:16]};
    pin[3]    = {1'h0, pin_bus.sync[28:22]};
    pin[4]    = pin_bus.sync[36:29];
    pin[5]    = pin_bus.sync[44:37];
    pin[7]    = pin_bus.sync[52:45];
    pin[8]    = {2'h0, pin_bus.sync[58:53]};
    pin[9]    = {4'h0, pin_bus.sync[62:59]};
  end

  // decode: does this word address name a real register
  function automatic logic reg_hit(input logic [7:0] a);
    logic [1:0] g;
    logic [3:0] i;
    g = a[ppm_pkg::GRP_MSB:ppm_pkg::GRP_LSB];
    i = a[ppm_pkg::IDX_MSB:ppm_pkg::IDX_LSB];
    case (g)
      ppm_pkg::GRP_DATA: reg_hit = ppm_pkg::DATA_MAP[i];
      ppm_pkg::GRP_DIR:  reg_hit = ppm_pkg::DIR_MAP[i];
      ppm_pkg::GRP_FSEL: reg_hit = ppm_pkg::FSEL_MAP[i];
      default: reg_hit = (i == ppm_pkg::IDX_MODE) ||
                         (i == ppm_pkg::IDX_EDGE);
    endcase
  endfunction : reg_hit

  always_comb begin
    logic [1:0] g;
    logic [3:0] i;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [7:0] inp;
    logic [5:0] rise;
    logic [5:0] fall;
    logic [5:0] hit;
    logic       ext;
    d    = q;
    g    = '0;
    i    = '0;
    wd   = q.wdata;
    rd   = '0;
    inp  = '0;
    rise = '0;
    fall = '0;
    hit  = '0;
    ext  = q.mode[ppm_pkg::MODE_EXTMEM];

    // write channel: address and data taken in either order
    if (s_axi_awvalid_i && q.awready) begin
      d.aw_ok  = 1'b1;
      d.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q.wready) begin
      d.w_ok  = 1'b1;
      d.wdata = s_axi_wdata_i[7:0];
      d.wstb  = s_axi_wstrb_i[0];
    end
    if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_ok && q.w_ok && !q.bvalid) begin
      g        = q.awaddr[ppm_pkg::GRP_MSB:ppm_pkg::GRP_LSB];
      i        = q.awaddr[ppm_pkg::IDX_MSB:ppm_pkg::IDX_LSB];
      d.aw_ok  = 1'b0;
      d.w_ok   = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = reg_hit(q.awaddr) ? ppm_pkg::RESP_OKAY
                                   : ppm_pkg::RESP_SLVERR;
      // ports two and seven have no latch; writes there are dropped
      if (reg_hit(q.awaddr) && q.wstb) begin
        case (g)
          ppm_pkg::GRP_DATA: begin
            if (ppm_pkg::DIR_MAP[i]) begin
              d.lat[i] = wd & ppm_pkg::PORT_MASK[i];
            end
          end
          ppm_pkg::GRP_DIR: begin
            // port four turns round as a whole byte
            if (i == 4'(ppm_pkg::P4)) begin
              d.dir[i] = {8{wd[0]}};
            end else begin
              d.dir[i] = wd | ~ppm_pkg::PORT_MASK[i];
            end
          end
          ppm_pkg::GRP_FSEL: begin
            d.fsel[i] = wd & ppm_pkg::PORT_MASK[i];
          end
          default: begin
            if (i == ppm_pkg::IDX_MODE) begin
              d.mode = wd;
            end else begin
              d.edge_pol = wd;
            end
          end
        endcase
      end
    end
    d.awready = !d.aw_ok;
    d.wready  = !d.w_ok;

    // read channel: one read at a time
    if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && q.arready) begin
      g = s_axi_araddr_i[ppm_pkg::GRP_MSB:ppm_pkg::GRP_LSB];
      i = s_axi_araddr_i[ppm_pkg::IDX_MSB:ppm_pkg::IDX_LSB];
      inp = q.dir[i] | q.fsel[i];
      case (g)
        ppm_pkg::GRP_DATA: begin
          rd = ((pin[i] & inp) | (q.lat[i] & ~inp))
               & ppm_pkg::PORT_MASK[i];
        end
        ppm_pkg::GRP_DIR:  rd = q.dir[i] & ppm_pkg::PORT_MASK[i];
        ppm_pkg::GRP_FSEL: rd = q.fsel[i];
        default: begin
          rd = (i == ppm_pkg::IDX_MODE) ? q.mode : q.edge_pol;
        end
      endcase
      d.rvalid = 1'b1;
      d.rdata  = reg_hit(s_axi_araddr_i) ? {24'h0, rd} : 32'h0;
      d.rresp  = reg_hit(s_axi_araddr_i) ? ppm_pkg::RESP_OKAY
                                         : ppm_pkg::RESP_SLVERR;
    end
    d.arready = !d.rvalid;

    // real-time buffer moves to the pins only on the trigger
    if (realtime_trigger_i) begin
      d.rtp = realtime_outputs_i;
    end

    // port mode defaults: latch out, driver on for output bits
    for (int p = 0; p < ppm_pkg::NPORT; p++) begin
      d.pin_o[p]  = q.lat[p];
      d.pin_oe[p] = ~q.dir[p] & ppm_pkg::PORT_MASK[p];
    end

    // port zero control roles
    for (int b = 0; b < ppm_pkg::RTP_W; b++) begin
      if (q.fsel[ppm_pkg::P0][b]) begin
        d.pin_o[ppm_pkg::P0][b]  = q.rtp[b];
        d.pin_oe[ppm_pkg::P0][b] = 1'b1;
      end
    end
    if (q.fsel[ppm_pkg::P0][ppm_pkg::P0_PWMA]) begin
      d.pin_o[ppm_pkg::P0][ppm_pkg::P0_PWMA]  = pulse_width_out_a_i;
      d.pin_oe[ppm_pkg::P0][ppm_pkg::P0_PWMA] = 1'b1;
    end
    if (q.fsel[ppm_pkg::P0][ppm_pkg::P0_PWMB]) begin
      d.pin_o[ppm_pkg::P0][ppm_pkg::P0_PWMB]  = pulse_width_out_b_i;
      d.pin_oe[ppm_pkg::P0][ppm_pkg::P0_PWMB] =
        !q.mode[ppm_pkg::MODE_P05_IN];
    end
    if (q.fsel[ppm_pkg::P0][ppm_pkg::P0_TMR]) begin
      d.pin_o[ppm_pkg::P0][ppm_pkg::P0_TMR]  = updown_timer_output_i;
      d.pin_oe[ppm_pkg::P0][ppm_pkg::P0_TMR] =
        !q.mode[ppm_pkg::MODE_P06_IN];
    end
    if (q.fsel[ppm_pkg::P0][ppm_pkg::P0_CLR]) begin
      d.pin_oe[ppm_pkg::P0][ppm_pkg::P0_CLR] = 1'b0;
    end
    // inputs to the timer read zero unless their pin is given to them
    d.tmr_dir = q.fsel[ppm_pkg::P0][ppm_pkg::P0_PWMB] &
                q.mode[ppm_pkg::MODE_P05_IN] &
                pin[ppm_pkg::P0][ppm_pkg::P0_PWMB];
    d.tmr_clk = q.fsel[ppm_pkg::P0][ppm_pkg::P0_TMR] &
                q.mode[ppm_pkg::MODE_P06_IN] &
                pin[ppm_pkg::P0][ppm_pkg::P0_TMR];
    d.tmr_clr = q.fsel[ppm_pkg::P0][ppm_pkg::P0_CLR] &
                pin[ppm_pkg::P0][ppm_pkg::P0_CLR];

    // port two: fixed control role, edges chosen per bit
    rise = pin[ppm_pkg::P2][5:0] & ~q.p2_prev;
    fall = ~pin[ppm_pkg::P2][5:0] & q.p2_prev;
    hit  = (rise & q.edge_pol[5:0]) | (fall & ~q.edge_pol[5:0]);
    d.p2_prev = pin[ppm_pkg::P2][5:0];
    d.nmi = hit[ppm_pkg::P2_NMI];
    d.irq = hit[5:ppm_pkg::P2_IRQ];
    d.ti  = pin[ppm_pkg::P2][ppm_pkg::P2_TI];

    // port three serial roles
    if (q.fsel[ppm_pkg::P3][ppm_pkg::P3_TXA]) begin
      d.pin_o[ppm_pkg::P3][ppm_pkg::P3_TXA]  = async_tx_a_i;
      d.pin_oe[ppm_pkg::P3][ppm_pkg::P3_TXA] = 1'b1;
    end
    if (q.fsel[ppm_pkg::P3][ppm_pkg::P3_RXA]) begin
      d.pin_oe[ppm_pkg::P3][ppm_pkg::P3_RXA] = 1'b0;
    end
    if (q.fsel[ppm_pkg::P3][ppm_pkg::P3_SO]) begin
      // bus lines only ever pull low; the board pulls them up
      d.pin_o[ppm_pkg::P3][ppm_pkg::P3_SO]  =
        serial_bus_mode_i ? 1'b0 : csi_out_a_i;
      d.pin_oe[ppm_pkg::P3][ppm_pkg::P3_SO] =
        serial_bus_mode_i ? !csi_out_a_i : 1'b1;
    end
    if (q.fsel[ppm_pkg::P3][ppm_pkg::P3_SI]) begin
      d.pin_o[ppm_pkg::P3][ppm_pkg::P3_SI]  = 1'b0;
      d.pin_oe[ppm_pkg::P3][ppm_pkg::P3_SI] =
        serial_bus_mode_i & !csi_out_b_i;
    end
    if (q.fsel[ppm_pkg::P3][ppm_pkg::P3_SCK]) begin
      d.pin_o[ppm_pkg::P3][ppm_pkg::P3_SCK]  = csi_clock_out_i;
      d.pin_oe[ppm_pkg::P3][ppm_pkg::P3_SCK] = csi_clock_oe_i;
    end
    if (q.fsel[ppm_pkg::P3][ppm_pkg::P3_TXB]) begin
      d.pin_o[ppm_pkg::P3][ppm_pkg::P3_TXB]  = async_tx_b_i;
      d.pin_oe[ppm_pkg::P3][ppm_pkg::P3_TXB] = 1'b1;
    end
    if (q.fsel[ppm_pkg::P3][ppm_pkg::P3_RXB]) begin
      d.pin_oe[ppm_pkg::P3][ppm_pkg::P3_RXB] = 1'b0;
    end
    // uart receivers idle high while their pin is a port
    d.rxa = !q.fsel[ppm_pkg::P3][ppm_pkg::P3_RXA] |
            pin[ppm_pkg::P3][ppm_pkg::P3_RXA];
    d.rxb = !q.fsel[ppm_pkg::P3][ppm_pkg::P3_RXB] |
            pin[ppm_pkg::P3][ppm_pkg::P3_RXB];
    d.sba = pin[ppm_pkg::P3][ppm_pkg::P3_SO];
    d.sbb = pin[ppm_pkg::P3][ppm_pkg::P3_SI];
    d.sck = pin[ppm_pkg::P3][ppm_pkg::P3_SCK];

    // port seven: inputs only, copied to the converter side
    d.ani = pin[ppm_pkg::P7];

    // port eight pulse outputs
    for (int b = 0; b < ppm_pkg::P8_W; b++) begin
      if (q.fsel[ppm_pkg::P8][b]) begin
        d.pin_o[ppm_pkg::P8][b]  = pulse_unit_outputs_i[b];
        d.pin_oe[ppm_pkg::P8][b] = 1'b1;
      end
    end

    // external memory takes ports four, five and strobes on nine
    if (ext) begin
      d.pin_o[ppm_pkg::P4]  = bus_ad_out_i;
      d.pin_oe[ppm_pkg::P4] = {8{bus_ad_oe_i}};
      d.pin_o[ppm_pkg::P5]  = bus_addr_hi_i;
      d.pin_oe[ppm_pkg::P5] = 8'hff;
      d.pin_o[ppm_pkg::P9][ppm_pkg::P9_RD]  = bus_rd_n_i;
      d.pin_o[ppm_pkg::P9][ppm_pkg::P9_WR]  = bus_wr_n_i;
      d.pin_oe[ppm_pkg::P9][ppm_pkg::P9_RD] = 1'b1;
      d.pin_oe[ppm_pkg::P9][ppm_pkg::P9_WR] = 1'b1;
    end
    d.ad_in = pin[ppm_pkg::P4];
    d.address_latch_strobe  = ext & bus_address_latch_strobe_i;
    d.wdt   = watchdog_overflow_i;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q          <= '0;
      q.lat      <= {ppm_pkg::NPORT{ppm_pkg::LAT_RST}};
      q.dir      <= {ppm_pkg::NPORT{ppm_pkg::DIR_RST}};
      q.fsel     <= {ppm_pkg::NPORT{ppm_pkg::FSEL_RST}};
      q.mode     <= ppm_pkg::MODE_RST;
      q.edge_pol <= ppm_pkg::EDGE_RST;
      q.awready  <= 1'b1;
      q.wready   <= 1'b1;
      q.arready  <= 1'b1;
      q.rxa      <= 1'b1;
      q.rxb      <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready_o = q.awready;
  assign s_axi_wready_o  = q.wready;
  assign s_axi_bvalid_o  = q.bvalid;
  assign s_axi_bresp_o   = q.bresp;
  assign s_axi_arready_o = q.arready;
  assign s_axi_rvalid_o  = q.rvalid;
  assign s_axi_rdata_o   = q.rdata;
  assign s_axi_rresp_o   = q.rresp;
  assign p0_o    = q.pin_o[ppm_pkg::P0];
  assign p0_oe_o = q.pin_oe[ppm_pkg::P0];
  assign p1_o    = q.pin_o[ppm_pkg::P1];
  assign p1_oe_o = q.pin_oe[ppm_pkg::P1];
  assign p3_o    = q.pin_o[ppm_pkg::P3][6:0];
  assign p3_oe_o = q.pin_oe[ppm_pkg::P3][6:0];
  assign p4_o    = q.pin_o[ppm_pkg::P4];
  assign p4_oe_o = q.pin_oe[ppm_pkg::P4];
  assign p5_o    = q.pin_o[ppm_pkg::P5];
  assign p5_oe_o = q.pin_oe[ppm_pkg::P5];
  assign p8_o    = q.pin_o[ppm_pkg::P8][5:0];
  assign p8_oe_o = q.pin_oe[ppm_pkg::P8][5:0];
  assign p9_o    = q.pin_o[ppm_pkg::P9][3:0];
  assign p9_oe_o = q.pin_oe[ppm_pkg::P9][3:0];
  assign address_latch_strobe_o       = q.address_latch_strobe;
  assign watchdog_overflow_out_o      = q.wdt;
  assign updown_timer_count_clock_o   = q.tmr_clk;
  assign updown_timer_direction_ctl_o = q.tmr_dir;
  assign updown_timer_clear_o         = q.tmr_clr;
  assign timer_one_count_clock_o      = q.ti;
  assign nmi_request_o                = q.nmi;
  assign external_irq_inputs_o        = q.irq;
  assign async_rx_a_o                 = q.rxa;
  assign async_rx_b_o                 = q.rxb;
  assign serial_bus_line_a_o          = q.sba;
  assign serial_bus_line_b_o          = q.sbb;
  assign csi_clock_in_o               = q.sck;
  assign analog_channel_inputs_o      = q.ani;
  assign bus_ad_in_o                  = q.ad_in;
  assign muxed_addr_data_bus_o        = q.ad_in;
endmodule : ppm_top

// >>> verification/ppm_board.sv
// board model: pin levels seen by the multiplexer
`timescale 1ns/1ps
module ppm_board #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] o_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] drv_i,
  output logic      [W-1:0] pin_o
);
  // a released line shows the board's level, not the last drive
  assign pin_o = (oe_i & o_i) | (~oe_i & drv_i);
endmodule : ppm_board

// >>> verification/ppm_top_monitor.sv
// bus and pin checks on the multiplexer's top ports
`timescale 1ns/1ps
module ppm_monitor (
  input wire logic clock_i, rstn_i, s_axi_awvalid_i, s_axi_awready_o,
  input wire logic s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o,
  input wire logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o,
  input wire logic s_axi_rvalid_o, s_axi_rready_i, nmi_request_o,
  input wire logic watchdog_overflow_i, watchdog_overflow_out_o,
  input wire logic [7:0] s_axi_araddr_i, p1_oe_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid_o)
    else $error("write answer late");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid_o &&
    !s_axi_arready_o) else $error("read answer late");
  a_b_done: assert property (s_axi_bvalid_o && s_axi_bready_i
    |=> !s_axi_bvalid_o) else $error("bvalid stuck");
  a_r_done: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
    !s_axi_rvalid_o && s_axi_arready_o) else $error("rvalid stuck");
  a_rdata_upper: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:8] == 24'h0) else $error("upper read bits set");
  a_unmapped_err: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i == 8'h18 |=> s_axi_rresp_o == ppm_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  a_wdt_follow: assert property ($rose(watchdog_overflow_i) |-> ##1
    watchdog_overflow_out_o) else $error("watchdog flag late");
  a_nmi_single: assert property (nmi_request_o |=> !nmi_request_o)
    else $error("nmi pulse too long");
  a_reset_float: assert property ($rose(rstn_i) |-> p1_oe_o == 8'h00)
    else $error("driver on after reset");
endmodule : ppm_monitor
bind ppm_top ppm_monitor u_mon (.*);

// >>> verification/ppm_top_tb.sv
// register-level tests of the pin multiplexer
`timescale 1ns/1ps
module ppm_top_tb;
  logic clock_i, rstn_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
  logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic realtime_trigger_i = 0, pulse_width_out_a_i = 0, bus_address_latch_strobe_i = 0;
  logic pulse_width_out_b_i = 0, updown_timer_output_i = 0, bus_rd_n_i = 0;
  logic async_tx_a_i = 0, async_tx_b_i = 0, serial_bus_mode_i = 0;
  logic csi_out_a_i = 0, csi_out_b_i = 0, csi_clock_out_i = 0;
  logic csi_clock_oe_i = 0, bus_ad_oe_i = 0, bus_wr_n_i = 0;
  logic watchdog_overflow_i = 0;
  logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, p4_i = 0, p5_i = 0;
  logic [7:0] p7_i = 0, bus_ad_out_i = 0, bus_addr_hi_i = 0, b0 = 0, b1 = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hf, realtime_outputs_i = 0, p9_i = 0;
  logic [5:0] p2_i = 0, p8_i = 0, pulse_unit_outputs_i = 0;
  logic [6:0] b3 = 0, p3_i, p3_o, p3_oe_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, address_latch_strobe_o, watchdog_overflow_out_o;
  logic updown_timer_count_clock_o, updown_timer_direction_ctl_o;
  logic updown_timer_clear_o, timer_one_count_clock_o, nmi_request_o;
  logic async_rx_a_o, async_rx_b_o, serial_bus_line_a_o, csi_clock_in_o;
  logic serial_bus_line_b_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [7:0] p0_i, p0_o, p0_oe_o, p1_i, p1_o, p1_oe_o, p4_o, p4_oe_o;
  logic [7:0] p5_o, p5_oe_o, analog_channel_inputs_o, bus_ad_in_o;
  logic [7:0] muxed_addr_data_bus_o;
  logic [5:0] p8_o, p8_oe_o;
  logic [4:0] external_irq_inputs_o;
  logic [3:0] p9_o, p9_oe_o;
  int n_fail = 0, n_checks = 0;
  ppm_top dut (.*);
  ppm_board #(8) u_b0 (.o_i(p0_o), .oe_i(p0_oe_o), .drv_i(b0), .pin_o(p0_i));
  ppm_board #(8) u_b1 (.o_i(p1_o), .oe_i(p1_oe_o), .drv_i(b1), .pin_o(p1_i));
  ppm_board #(7) u_b3 (.o_i(p3_o), .oe_i(p3_oe_o), .drv_i(b3), .pin_o(p3_i));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic print_verdict;
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tk
  task automatic wr(input logic [7:0] a, d, input logic [1:0] r = 2'h0);
    @(posedge clock_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    // address and data may be taken on different edges
    do begin
      @(posedge clock_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while ((s_axi_awvalid_i && !s_axi_awready_o) ||
               (s_axi_wvalid_i && !s_axi_wready_o));
    do @(posedge clock_i); while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
    chk(s_axi_bresp_o, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, e, input logic [1:0] r = 2'h0);
    @(posedge clock_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge clock_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clock_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    chk({s_axi_rresp_o, s_axi_rdata_o[7:0]}, {r, e});
  endtask : rd
  task automatic irq(input int b);
    logic [5:0] seen;
    int n;
    seen = '0;
    n = 0;
    @(posedge clock_i);
    p2_i[b] <= 1'b1;
    repeat (6) begin
      @(posedge clock_i);
      seen = seen | {external_irq_inputs_o, nmi_request_o};
      if ({external_irq_inputs_o, nmi_request_o} !== 6'h0) n++;
    end
    chk(seen, 32'h1 << b);
    chk(n, 1);
  endtask : irq
  initial begin
    tk(4000);
    n_fail++;
    print_verdict;
  end
  initial begin
    tk(2);
    rstn_i <= 1'b1;
    chk({p0_oe_o, p1_oe_o, p3_oe_o}, 0);
    rd(8'h40, 8'hff);
    b1 <= 8'h3c;
    wr(8'h04, 8'ha5);
    wr(8'h44, 8'h0f);
    tk(4);
    chk({p1_oe_o, p1_o[7:4]}, 12'hf0a);
    rd(8'h04, 8'hac);
    realtime_outputs_i <= 4'h9;
    pulse_width_out_a_i <= 1'b1;
    wr(8'h00, 8'h0f);
    wr(8'h40, 8'h00);
    tk(2);
    chk({p0_oe_o, p0_o}, 16'hff0f);
    wr(8'h80, 8'h3f);
    tk(2);
    chk(p0_o[5:0], 6'h10);
    realtime_trigger_i <= 1'b1;
    @(posedge clock_i) realtime_trigger_i <= 1'b0;
    tk(3);
    chk(p0_o[5:0], 6'h19);
    b0 <= 8'he0;
    updown_timer_output_i <= 1'b1;
    wr(8'h80, 8'hff);
    wr(8'hc0, 8'h02);
    tk(4);
    chk({p0_oe_o[7:5], p0_o[6], updown_timer_clear_o,
      updown_timer_direction_ctl_o}, 6'b010111);
    wr(8'hc0, 8'h04);
    tk(4);
    chk({p0_oe_o[6:5], updown_timer_count_clock_o,
      updown_timer_direction_ctl_o}, 4'b0110);
    for (int b = 0; b < 6; b++) irq(b);
    chk(timer_one_count_clock_o, 1);
    rd(8'h08, 8'h3f);
    async_tx_a_i <= 1'b1;
    b3 <= 7'h18;
    wr(8'h8c, 8'h7f);
    tk(4);
    chk({p3_oe_o[1:0], p3_o[0], async_rx_a_o,
      serial_bus_line_b_o, csi_clock_in_o}, 6'b011011);
    serial_bus_mode_i <= 1'b1;
    csi_out_b_i <= 1'b1;
    tk(2);
    chk({p3_oe_o[3:2], p3_o[3:2]}, 4'b0100);
    p7_i <= 8'h5a;
    tk(4);
    chk(analog_channel_inputs_o, 8'h5a);
    rd(8'h1c, 8'h5a);
    rd(8'h18, 8'h00, ppm_pkg::RESP_SLVERR);
    wr(8'hfc, 8'h00, ppm_pkg::RESP_SLVERR);
    bus_ad_oe_i <= 1'b1;
    bus_ad_out_i <= 8'h3c;
    bus_rd_n_i <= 1'b1;
    bus_address_latch_strobe_i <= 1'b1;
    p4_i <= 8'h77;
    wr(8'hc0, 8'h01);
    tk(2);
    chk({p4_oe_o, p4_o, p5_oe_o}, 24'hff3cff);
    chk({p9_oe_o[1:0], p9_o[1:0],
      address_latch_strobe_o}, 5'b11011);
    chk({bus_ad_in_o, muxed_addr_data_bus_o}, 16'h7777);
    pulse_unit_outputs_i <= 6'h2a;
    wr(8'ha0, 8'h3f);
    tk(2);
    chk({p8_oe_o, p8_o}, 12'hfea);
    watchdog_overflow_i <= 1'b1;
    tk(3);
    chk(watchdog_overflow_out_o, 1);
    print_verdict;
  end
endmodule : ppm_top_tb
